// ### src/cid_pkg.sv
// shared types and constants of the instruction class decoder
package cid_pkg;

  typedef enum logic [2:0] {
    CLS_REGMEM  = 3'b000,
    CLS_RMW     = 3'b001,
    CLS_JUMP    = 3'b010,
    CLS_BRANCH  = 3'b011,
    CLS_BITMAN  = 3'b100,
    CLS_CONTROL = 3'b101,
    CLS_ILLEGAL = 3'b110
  } cid_class_t;

  typedef enum logic [2:0] {
    AM_INH = 3'b000,
    AM_IMM = 3'b001,
    AM_DIR = 3'b010,
    AM_EXT = 3'b011,
    AM_IX  = 3'b100,
    AM_IX1 = 3'b101,
    AM_IX2 = 3'b110,
    AM_REL = 3'b111
  } cid_mode_t;

  typedef enum logic [1:0] {
    REG_NONE  = 2'b00,
    REG_ACC   = 2'b01,
    REG_INDEX = 2'b10,
    REG_MEM   = 2'b11
  } cid_reg_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cid_flags_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [15:0] pc;
    logic [7:0] index;
    logic [7:0] mem_byte;
    cid_flags_t flags;
  } cid_req_t;

  typedef struct packed {
    logic valid;
    cid_class_t cls;
    cid_mode_t mode;
    cid_reg_t reg_sel;
    cid_reg_t wb_target;
    logic writeback;
    logic [1:0] length;
    logic [3:0] cycles;
    logic [4:0] osc_cycles;
    logic [15:0] ea;
    logic [15:0] next_pc;
    logic branch;
    logic taken;
    logic [15:0] target;
    logic [2:0] bit_idx;
    logic bit_want;
    logic carry_load;
    logic carry_val;
    logic is_multiply;
  } cid_res_t;

  // opcode rows (high nibble)
  localparam logic [3:0] ROW_BITBR = 4'h0;
  localparam logic [3:0] ROW_BITMAN = 4'h1;
  localparam logic [3:0] ROW_BRANCH = 4'h2;
  localparam logic [3:0] ROW_RMW_DIR = 4'h3;
  localparam logic [3:0] ROW_RMW_ACC = 4'h4;
  localparam logic [3:0] ROW_RMW_X = 4'h5;
  localparam logic [3:0] ROW_RMW_IX1 = 4'h6;
  localparam logic [3:0] ROW_RMW_IX = 4'h7;
  localparam logic [3:0] ROW_CTRL_LO = 4'h8;
  localparam logic [3:0] ROW_CTRL_HI = 4'h9;
  localparam logic [3:0] ROW_IMM = 4'ha;
  localparam logic [3:0] ROW_DIR = 4'hb;
  localparam logic [3:0] ROW_EXT = 4'hc;
  localparam logic [3:0] ROW_IX2 = 4'hd;
  localparam logic [3:0] ROW_IX1 = 4'he;
  localparam logic [3:0] ROW_IX = 4'hf;

  // opcode columns (low nibble)
  localparam logic [3:0] COL_TEST_NZ = 4'hd;
  localparam logic [3:0] COL_JUMP = 4'hc;
  localparam logic [3:0] COL_JUMP_SUB = 4'hd;
  localparam logic [3:0] COL_CPX = 4'h3;
  localparam logic [3:0] COL_LDX = 4'he;
  localparam logic [15:0] RMW_COL_MASK = 16'hb7d9;

  localparam logic [7:0] OP_MULTIPLY = 8'h42;
  localparam logic [7:0] OP_BSR = 8'had;
  localparam logic [7:0] OP_BRANCH_LS = 8'h23;
  localparam logic [7:0] OP_BRANCH_HI = 8'h22;
  localparam logic [7:0] ZERO_PAGE_HI = 8'h00;

  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // internal cycles
  localparam logic [3:0] CYC_MULTIPLY = 4'hb;
  localparam logic [3:0] CYC_BITBR = 4'h5;
  localparam logic [3:0] CYC_BITMAN = 4'h5;
  localparam logic [3:0] CYC_BRANCH = 4'h3;
  localparam logic [3:0] CYC_BSR = 4'h6;
  localparam logic [3:0] CYC_CTRL = 4'h2;
  localparam logic [3:0] CYC_JUMP_SUB_EXTRA = 4'h3;
  localparam logic [3:0] CYC_RM_IMM = 4'h2;
  localparam logic [3:0] CYC_RM_DIR = 4'h3;
  localparam logic [3:0] CYC_RM_EXT = 4'h4;
  localparam logic [3:0] CYC_RM_IX2 = 4'h5;
  localparam logic [3:0] CYC_RM_IX1 = 4'h4;
  localparam logic [3:0] CYC_RM_IX = 4'h3;
  localparam logic [3:0] CYC_RMW_DIR = 4'h5;
  localparam logic [3:0] CYC_RMW_INH = 4'h3;
  localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
  localparam logic [3:0] CYC_RMW_IX = 4'h5;
  localparam logic [3:0] CYC_JMP_DIR = 4'h2;
  localparam logic [3:0] CYC_JMP_EXT = 4'h3;
  localparam logic [3:0] CYC_JMP_IX2 = 4'h4;
  localparam logic [3:0] CYC_JMP_IX1 = 4'h3;
  localparam logic [3:0] CYC_JMP_IX = 4'h2;

  // oscillator cycles per internal cycle
  localparam int OSC_PER_CYCLE = 2;

endpackage

// ### src/cid_cond.sv
// branch condition evaluator for the relative branch row
`timescale 1ns/1ps
`default_nettype none
module cid_cond (
  input wire logic [2:0] sel,
  input wire logic invert,
  input wire cid_pkg::cid_flags_t flags,
  input wire logic irq_level,
  output logic cond_true
);
  logic base;

  always_comb begin
    base = 1'b1;
    unique case (sel)
      3'h0: base = 1'b1;
      3'h1: base = ~(flags.c | flags.z);
      3'h2: base = ~flags.c;
      3'h3: base = ~flags.z;
      3'h4: base = ~flags.h;
      3'h5: base = ~flags.n;
      3'h6: base = ~flags.i;
      3'h7: base = ~irq_level;
    endcase
    // odd opcode of each pair tests the opposite sense
    cond_true = base ^ invert;
  end
endmodule
`default_nettype wire

// ### src/cid_decoder.sv
// instruction class and addressing mode decoder
`timescale 1ns/1ps
`default_nettype none
// How it works
// - register/memory: register plus memory, never relative
// - read-modify-write writes result back to source
// - test-negative-zero skips the write-back
// - read-modify-write: inherent, direct, indexed, indexed-8
// - jumps: no register, direct/extended/three indexed modes
// - branches relative; false condition falls through
// - bit-test-branch: opcode, direct byte, offset byte
// - bit number and sense come from opcode
// - taken target is next address plus signed offset
// - tested bit always copied into carry
// - bit set/clear use direct page addressing
// - control instructions are inherent only
// - time counted in internal cycles, two oscillator each
// - multiply is register/memory, index times accumulator
// - branches test flags and interrupt line level
// - lower-or-same on carry or zero; higher otherwise
// - direct address high byte forced to zero
module cid_decoder #(
  parameter int OSC_PER_CYCLE = cid_pkg::OSC_PER_CYCLE
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic irq_line,
  input wire cid_pkg::cid_req_t req,
  output var cid_pkg::cid_res_t res
);
  typedef struct packed {
    logic irq_meta;
    logic irq_sync;
    cid_pkg::cid_res_t res;
  } cid_state_t;

  if (OSC_PER_CYCLE < 1 || OSC_PER_CYCLE * 15 > 31) begin : g_bad_ratio
    $error("oscillator ratio does not fit the cycle count field");
  end

  cid_state_t st;
  cid_state_t next_st;
  logic rst_meta;
  logic rst_sync;
  logic cond_true;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  cid_cond u_cond (
    .sel(req.opcode[3:1]),
    .invert(req.opcode[0]),
    .flags(req.flags),
    .irq_level(st.irq_sync),
    .cond_true(cond_true)
  );

  function automatic logic [1:0] len_of(cid_pkg::cid_mode_t m);
    case (m)
      cid_pkg::AM_INH, cid_pkg::AM_IX: len_of = cid_pkg::LEN_1;
      cid_pkg::AM_EXT, cid_pkg::AM_IX2: len_of = cid_pkg::LEN_3;
      default: len_of = cid_pkg::LEN_2;
    endcase
  endfunction

  function automatic logic [15:0] ea_of(cid_pkg::cid_mode_t m, logic [7:0] a,
                                        logic [7:0] b, logic [7:0] x);
    case (m)
      cid_pkg::AM_DIR: ea_of = {cid_pkg::ZERO_PAGE_HI, a};
      cid_pkg::AM_EXT: ea_of = {a, b};
      cid_pkg::AM_IX: ea_of = {cid_pkg::ZERO_PAGE_HI, x};
      cid_pkg::AM_IX1: ea_of = {cid_pkg::ZERO_PAGE_HI, a} + {cid_pkg::ZERO_PAGE_HI, x};
      cid_pkg::AM_IX2: ea_of = {a, b} + {cid_pkg::ZERO_PAGE_HI, x};
      default: ea_of = 16'h0000;
    endcase
  endfunction

  function automatic logic [3:0] rm_cyc(cid_pkg::cid_mode_t m);
    case (m)
      cid_pkg::AM_IMM: rm_cyc = cid_pkg::CYC_RM_IMM;
      cid_pkg::AM_DIR: rm_cyc = cid_pkg::CYC_RM_DIR;
      cid_pkg::AM_EXT: rm_cyc = cid_pkg::CYC_RM_EXT;
      cid_pkg::AM_IX2: rm_cyc = cid_pkg::CYC_RM_IX2;
      cid_pkg::AM_IX1: rm_cyc = cid_pkg::CYC_RM_IX1;
      default: rm_cyc = cid_pkg::CYC_RM_IX;
    endcase
  endfunction

  function automatic logic [3:0] jump_cyc(cid_pkg::cid_mode_t m);
    case (m)
      cid_pkg::AM_DIR: jump_cyc = cid_pkg::CYC_JMP_DIR;
      cid_pkg::AM_EXT: jump_cyc = cid_pkg::CYC_JMP_EXT;
      cid_pkg::AM_IX2: jump_cyc = cid_pkg::CYC_JMP_IX2;
      cid_pkg::AM_IX1: jump_cyc = cid_pkg::CYC_JMP_IX1;
      default: jump_cyc = cid_pkg::CYC_JMP_IX;
    endcase
  endfunction

  always_comb begin
    cid_pkg::cid_res_t r;
    logic [3:0] hi;
    logic [3:0] lo;
    logic [7:0] rel;
    logic bitv;
    r = '0;
    hi = req.opcode[7:4];
    lo = req.opcode[3:0];
    rel = req.op1;
    bitv = req.mem_byte[req.opcode[3:1]];
    next_st = st;
    next_st.irq_meta = irq_line;
    next_st.irq_sync = st.irq_meta;
    r.valid = req.valid;
    r.cls = cid_pkg::CLS_ILLEGAL;
    r.mode = cid_pkg::AM_INH;
    r.bit_idx = req.opcode[3:1];
    r.bit_want = ~req.opcode[0];
    unique case (hi)
      cid_pkg::ROW_BITBR: begin
        r.cls = cid_pkg::CLS_BITMAN;
        r.mode = cid_pkg::AM_DIR;
        r.cycles = cid_pkg::CYC_BITBR;
        r.branch = 1'b1;
        rel = req.op2;
        r.taken = (bitv == r.bit_want);
        r.carry_load = 1'b1;
        r.carry_val = bitv;
      end
      cid_pkg::ROW_BITMAN: begin
        r.cls = cid_pkg::CLS_BITMAN;
        r.mode = cid_pkg::AM_DIR;
        r.cycles = cid_pkg::CYC_BITMAN;
        r.writeback = 1'b1;
        r.wb_target = cid_pkg::REG_MEM;
      end
      cid_pkg::ROW_BRANCH: begin
        r.cls = cid_pkg::CLS_BRANCH;
        r.mode = cid_pkg::AM_REL;
        r.cycles = cid_pkg::CYC_BRANCH;
        r.branch = 1'b1;
        r.taken = cond_true;
      end
      cid_pkg::ROW_RMW_DIR, cid_pkg::ROW_RMW_ACC, cid_pkg::ROW_RMW_X,
      cid_pkg::ROW_RMW_IX1, cid_pkg::ROW_RMW_IX: begin
        if (req.opcode == cid_pkg::OP_MULTIPLY) begin
          r.cls = cid_pkg::CLS_REGMEM;
          r.reg_sel = cid_pkg::REG_INDEX;
          r.cycles = cid_pkg::CYC_MULTIPLY;
          r.is_multiply = 1'b1;
        end else if (cid_pkg::RMW_COL_MASK[lo]) begin
          r.cls = cid_pkg::CLS_RMW;
          r.writeback = (lo != cid_pkg::COL_TEST_NZ);
          r.cycles = cid_pkg::CYC_RMW_INH;
          if (hi == cid_pkg::ROW_RMW_DIR) begin
            r.mode = cid_pkg::AM_DIR;
            r.cycles = cid_pkg::CYC_RMW_DIR;
            r.reg_sel = cid_pkg::REG_MEM;
          end else if (hi == cid_pkg::ROW_RMW_ACC) begin
            r.reg_sel = cid_pkg::REG_ACC;
          end else if (hi == cid_pkg::ROW_RMW_X) begin
            r.reg_sel = cid_pkg::REG_INDEX;
          end else if (hi == cid_pkg::ROW_RMW_IX1) begin
            r.mode = cid_pkg::AM_IX1;
            r.cycles = cid_pkg::CYC_RMW_IX1;
            r.reg_sel = cid_pkg::REG_MEM;
          end else begin
            r.mode = cid_pkg::AM_IX;
            r.cycles = cid_pkg::CYC_RMW_IX;
            r.reg_sel = cid_pkg::REG_MEM;
          end
          r.wb_target = r.writeback ? r.reg_sel : cid_pkg::REG_NONE;
        end
      end
      cid_pkg::ROW_CTRL_LO, cid_pkg::ROW_CTRL_HI: begin
        r.cls = cid_pkg::CLS_CONTROL;
        r.cycles = cid_pkg::CYC_CTRL;
      end
      cid_pkg::ROW_IMM, cid_pkg::ROW_DIR, cid_pkg::ROW_EXT,
      cid_pkg::ROW_IX2, cid_pkg::ROW_IX1, cid_pkg::ROW_IX: begin
        r.mode = (hi == cid_pkg::ROW_IMM) ? cid_pkg::AM_IMM :
                 (hi == cid_pkg::ROW_DIR) ? cid_pkg::AM_DIR :
                 (hi == cid_pkg::ROW_EXT) ? cid_pkg::AM_EXT :
                 (hi == cid_pkg::ROW_IX2) ? cid_pkg::AM_IX2 :
                 (hi == cid_pkg::ROW_IX1) ? cid_pkg::AM_IX1 : cid_pkg::AM_IX;
        if (lo == cid_pkg::COL_JUMP || lo == cid_pkg::COL_JUMP_SUB) begin
          if (req.opcode == cid_pkg::OP_BSR) begin
            r.cls = cid_pkg::CLS_BRANCH;
            r.mode = cid_pkg::AM_REL;
            r.cycles = cid_pkg::CYC_BSR;
            r.branch = 1'b1;
            r.taken = 1'b1;
          end else if (hi != cid_pkg::ROW_IMM) begin
            r.cls = cid_pkg::CLS_JUMP;
            r.reg_sel = cid_pkg::REG_NONE;
            r.taken = 1'b1;
            r.cycles = jump_cyc(r.mode) +
                       ((lo == cid_pkg::COL_JUMP_SUB) ? cid_pkg::CYC_JUMP_SUB_EXTRA : 4'h0);
          end else begin
            r.mode = cid_pkg::AM_INH;
          end
        end else begin
          r.cls = cid_pkg::CLS_REGMEM;
          r.reg_sel = (lo == cid_pkg::COL_CPX || lo == cid_pkg::COL_LDX) ?
                      cid_pkg::REG_INDEX : cid_pkg::REG_ACC;
          r.cycles = rm_cyc(r.mode);
        end
      end
    endcase
    r.length = (hi == cid_pkg::ROW_BITBR) ? cid_pkg::LEN_3 : len_of(r.mode);
    r.ea = ea_of(r.mode, req.op1, req.op2, req.index);
    r.next_pc = req.pc + {14'h0000, r.length};
    if (r.cls == cid_pkg::CLS_JUMP) begin
      r.target = r.ea;
    end else if (r.branch && r.taken) begin
      r.target = r.next_pc + {{8{rel[7]}}, rel};
    end else begin
      r.target = r.next_pc;
    end
    r.osc_cycles = 5'(r.cycles * OSC_PER_CYCLE);
    next_st.res = r;
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign res = st.res;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync);

  sequence s_bitbr_req;
    req.valid && req.opcode[7:4] == cid_pkg::ROW_BITBR;
  endsequence
  sequence s_bitbr_res;
    res.valid && res.length == cid_pkg::LEN_3 && res.carry_load;
  endsequence

  chk_regmem_norel: assert property (
    res.valid && res.cls == cid_pkg::CLS_REGMEM |-> res.mode != cid_pkg::AM_REL)
    else $error("register/memory decoded as relative");
  chk_test_no_wb: assert property (
    res.valid && res.cls == cid_pkg::CLS_RMW |->
    res.writeback == ($past(req.opcode[3:0]) != cid_pkg::COL_TEST_NZ))
    else $error("read-modify-write write-back wrong");
  chk_rmw_modes: assert property (
    res.valid && res.cls == cid_pkg::CLS_RMW |-> res.mode inside
    {cid_pkg::AM_INH, cid_pkg::AM_DIR, cid_pkg::AM_IX, cid_pkg::AM_IX1})
    else $error("read-modify-write in illegal mode");
  chk_jump_noreg: assert property (
    res.valid && res.cls == cid_pkg::CLS_JUMP |->
    res.reg_sel == cid_pkg::REG_NONE && res.target == res.ea && res.mode != cid_pkg::AM_IMM)
    else $error("jump decoded with register or wrong target");
  chk_bitbr_form: assert property (
    s_bitbr_req |=> s_bitbr_res ##0 res.ea == {cid_pkg::ZERO_PAGE_HI, $past(req.op1)})
    else $error("bit-test-branch format wrong");
  chk_bit_carry: assert property (
    s_bitbr_req |=> res.carry_load &&
    res.carry_val == $past(req.mem_byte[req.opcode[3:1]]))
    else $error("tested bit not copied to carry");
  chk_bitbr_taken: assert property (
    s_bitbr_req |=>
    res.taken == ($past(req.mem_byte[req.opcode[3:1]]) != $past(req.opcode[0])))
    else $error("bit-test-branch condition wrong");
  chk_bitbr_target: assert property (
    s_bitbr_req |=> res.target == (res.taken ?
    res.next_pc + {{8{$past(req.op2[7])}}, $past(req.op2)} : res.next_pc))
    else $error("bit-test-branch target wrong");
  chk_lower_same: assert property (
    req.valid && req.opcode == cid_pkg::OP_BRANCH_LS |=>
    res.taken == ($past(req.flags.c) | $past(req.flags.z)))
    else $error("lower-or-same condition wrong");
  chk_higher_cond: assert property (
    req.valid && req.opcode == cid_pkg::OP_BRANCH_HI |=>
    res.taken == !($past(req.flags.c) | $past(req.flags.z)))
    else $error("higher condition wrong");
  chk_multiply_time: assert property (
    req.valid && req.opcode == cid_pkg::OP_MULTIPLY |=> res.is_multiply &&
    res.cls == cid_pkg::CLS_REGMEM &&
    res.osc_cycles == 5'(cid_pkg::CYC_MULTIPLY * OSC_PER_CYCLE))
    else $error("multiply decode or timing wrong");
  chk_control_inh: assert property (
    res.valid && res.cls == cid_pkg::CLS_CONTROL |->
    res.mode == cid_pkg::AM_INH && res.length == cid_pkg::LEN_1)
    else $error("control instruction not inherent");
endmodule
`default_nettype wire

// ### verif/cid_mem_model.sv
// far-side byte store answering the direct-page read of the decoder
`timescale 1ns/1ps
`default_nettype none
module cid_mem_model (
  input wire logic [7:0] addr,
  output logic [7:0] data
);
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 37 + 19);
    end
  end
  // only the first 256 addresses are reachable by a direct read
  assign data = mem[addr];
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench of the instruction class decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic resetn;
  logic irq_line;
  logic [15:0] pc;
  logic [7:0] ix;
  logic [7:0] mem_q;
  cid_pkg::cid_flags_t fl;
  cid_pkg::cid_req_t rq;
  cid_pkg::cid_req_t req_in;
  cid_pkg::cid_res_t res;
  int fails;
  int samples_checked;
  localparam cid_pkg::cid_mode_t MM [6] = '{cid_pkg::AM_IMM, cid_pkg::AM_DIR, cid_pkg::AM_EXT,
    cid_pkg::AM_IX2, cid_pkg::AM_IX1, cid_pkg::AM_IX};
  localparam logic [1:0] ML [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
  localparam logic [3:0] MC [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
  localparam cid_pkg::cid_mode_t RM [5] = '{cid_pkg::AM_DIR, cid_pkg::AM_INH, cid_pkg::AM_INH,
    cid_pkg::AM_IX1, cid_pkg::AM_IX};
  localparam logic [1:0] RL [5] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h1};
  localparam logic [3:0] RC [5] = '{4'h5, 4'h3, 4'h3, 4'h6, 4'h5};
  localparam cid_pkg::cid_reg_t RT [5] = '{cid_pkg::REG_MEM, cid_pkg::REG_ACC,
    cid_pkg::REG_INDEX, cid_pkg::REG_MEM, cid_pkg::REG_MEM};
  localparam logic [7:0] CTL [12] = '{8'h97, 8'h9f, 8'h99, 8'h98, 8'h9b, 8'h9a, 8'h83, 8'h80,
    8'h9c, 8'h9d, 8'h8e, 8'h8f};

  cid_decoder #(.OSC_PER_CYCLE(2)) dut (
    .clk(clk),
    .resetn(resetn),
    .irq_line(irq_line),
    .req(req_in),
    .res(res)
  );
  cid_mem_model mem (
    .addr(rq.op1),
    .data(mem_q)
  );

  always_comb begin
    req_in = rq;
    req_in.mem_byte = mem_q;
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [7:0] mb(input logic [7:0] a);
    return 8'(int'(a) * 37 + 19);
  endfunction

  function automatic logic [15:0] ea_of(input int k, input logic [7:0] a, input logic [7:0] b);
    case (k)
      1: return {8'h00, a};
      2: return {a, b};
      3: return {a, b} + {8'h00, ix};
      4: return {8'h00, a} + {8'h00, ix};
      default: return {8'h00, ix};
    endcase
  endfunction

  function automatic logic cond(input logic [3:0] c, input cid_pkg::cid_flags_t g, input logic q);
    logic v;
    case (c[3:1])
      3'h0: v = 1'b0;
      3'h1: v = g.c | g.z;
      3'h2: v = g.c;
      3'h3: v = g.z;
      3'h4: v = g.h;
      3'h5: v = g.n;
      3'h6: v = g.i;
      default: v = q;
    endcase
    return v ^ ~c[0];
  endfunction

  task automatic stop_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic go(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    rq <= '{1'b1, op, a, b, pc, ix, 8'h00, fl};
    @(posedge clk);
    rq.valid <= 1'b0;
    #1;
    ck("valid", 16'h1, 16'(res.valid));
  endtask

  task automatic cm(input logic [2:0] c, input logic [2:0] m, input logic [1:0] l,
    input logic [3:0] y);
    ck("cls", 16'(c), 16'(res.cls));
    ck("mode", 16'(m), 16'(res.mode));
    ck("len", 16'(l), 16'(res.length));
    ck("next", pc + 16'(l), res.next_pc);
    ck("cyc", 16'(y), 16'(res.cycles));
    ck("osc", 16'(y) * 16'h2, 16'(res.osc_cycles));
  endtask

  task automatic t_bitbr;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] m;
    logic bt;
    pc = 16'h0100;
    for (int k = 0; k < 16; k++) begin
      a = 8'(k * 29 + 3);
      b = k[1] ? 8'h80 : 8'h7f;
      m = mb(a);
      bt = m[k[3:1]];
      go(8'(k), a, b);
      cm(cid_pkg::CLS_BITMAN, cid_pkg::AM_DIR, 2'h3, 4'h5);
      ck("ea", {8'h00, a}, res.ea);
      ck("bit", 16'(k[3:1]), 16'(res.bit_idx));
      ck("want", 16'(!k[0]), 16'(res.bit_want));
      ck("taken", 16'(bt == !k[0]), 16'(res.taken));
      ck("tgt", bt == !k[0] ? pc + 16'h3 + {{8{b[7]}}, b} : pc + 16'h3, res.target);
      ck("cld", 16'h1, 16'(res.carry_load));
      ck("cval", 16'(bt), 16'(res.carry_val));
      ck("br", 16'h1, 16'(res.branch));
    end
  endtask

  task automatic t_bitman;
    logic [7:0] a;
    for (int k = 0; k < 16; k++) begin
      a = 8'(k * 17 + 5);
      go(8'h10 + 8'(k), a, 8'h00);
      cm(cid_pkg::CLS_BITMAN, cid_pkg::AM_DIR, 2'h2, 4'h5);
      ck("ea", {8'h00, a}, res.ea);
      ck("bit", 16'(k[3:1]), 16'(res.bit_idx));
      ck("want", 16'(!k[0]), 16'(res.bit_want));
      ck("br", 16'h0, 16'(res.branch));
      ck("wbt", 16'(cid_pkg::REG_MEM), 16'(res.wb_target));
    end
  endtask

  task automatic t_branch;
    logic [7:0] b;
    logic t;
    pc = 16'h0ff0;
    for (int q = 0; q < 2; q++) begin
      // the pin passes two flops before it is seen
      @(posedge clk);
      irq_line <= q[0];
      repeat (3) @(posedge clk);
      for (int f = 0; f < 32; f++) begin
        fl = cid_pkg::cid_flags_t'(f[4:0]);
        for (int k = 0; k < 16; k++) begin
          b = k[0] ? 8'h7f : 8'h80;
          t = cond(k[3:0], fl, q[0]);
          go(8'h20 + 8'(k), b, 8'h00);
          cm(cid_pkg::CLS_BRANCH, cid_pkg::AM_REL, 2'h2, 4'h3);
          ck("taken", 16'(t), 16'(res.taken));
          ck("tgt", t ? pc + 16'h2 + {{8{b[7]}}, b} : pc + 16'h2, res.target);
        end
      end
    end
  endtask

  task automatic t_rmw;
    ix = 8'hf0;
    for (int r = 0; r < 5; r++) begin
      for (int t = 0; t < 2; t++) begin
        go({4'(r + 3), t[0] ? 4'hd : 4'hc}, 8'h20, 8'h00);
        cm(cid_pkg::CLS_RMW, RM[r], RL[r], RC[r]);
        ck("wb", 16'(!t[0]), 16'(res.writeback));
        ck("wbt", t[0] ? 16'h0 : 16'(RT[r]), 16'(res.wb_target));
        if (r != 1 && r != 2) begin
          ck("ea", ea_of(r + 1, 8'h20, 8'h00), res.ea);
        end
      end
    end
  endtask

  task automatic t_jump;
    ix = 8'h20;
    for (int r = 1; r < 6; r++) begin
      for (int t = 0; t < 2; t++) begin
        go({4'(r + 10), t[0] ? 4'hd : 4'hc}, 8'hff, 8'hf0);
        cm(cid_pkg::CLS_JUMP, MM[r], ML[r], MC[r] - 4'h1 + (t[0] ? 4'h3 : 4'h0));
        ck("reg", 16'(cid_pkg::REG_NONE), 16'(res.reg_sel));
        ck("tgt", ea_of(r, 8'hff, 8'hf0), res.target);
      end
    end
    go(8'hac, 8'hff, 8'hf0);
    cm(cid_pkg::CLS_ILLEGAL, cid_pkg::AM_INH, 2'h1, 4'h0);
    go(8'had, 8'h80, 8'h00);
    cm(cid_pkg::CLS_BRANCH, cid_pkg::AM_REL, 2'h2, 4'h6);
    ck("tgt", pc + 16'h2 + 16'hff80, res.target);
  endtask

  task automatic t_regmem;
    for (int r = 0; r < 6; r++) begin
      for (int t = 0; t < 2; t++) begin
        go({4'(r + 10), t[0] ? 4'he : 4'h6}, 8'h12, 8'h34);
        cm(cid_pkg::CLS_REGMEM, MM[r], ML[r], MC[r]);
        ck("reg", t[0] ? 16'(cid_pkg::REG_INDEX) : 16'(cid_pkg::REG_ACC), 16'(res.reg_sel));
      end
    end
    go(8'h42, 8'h00, 8'h00);
    cm(cid_pkg::CLS_REGMEM, cid_pkg::AM_INH, 2'h1, 4'hb);
    ck("multiply", 16'h1, 16'(res.is_multiply));
    ck("reg", 16'(cid_pkg::REG_INDEX), 16'(res.reg_sel));
  endtask

  task automatic t_ctrl;
    for (int k = 0; k < 12; k++) begin
      go(CTL[k], 8'h00, 8'h00);
      cm(cid_pkg::CLS_CONTROL, cid_pkg::AM_INH, 2'h1, 4'h2);
    end
  endtask

  initial begin
    #400000;
    fails++;
    stop_test;
  end

  initial begin
    resetn = 1'b0;
    irq_line = 1'b0;
    rq = '0;
    pc = 16'h0200;
    ix = 8'h00;
    fl = '0;
    fails = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_bitbr;
    t_bitman;
    t_branch;
    t_rmw;
    t_jump;
    t_regmem;
    t_ctrl;
    stop_test;
  end
endmodule
`default_nettype wire
